// >>> asr_defs.vh
// Purpose: Shared constants for the serial readout and conversion control block
// Assumes: 10 MHz system clock; times in ns unless named otherwise
// Notes:   Cycle counts derive from these times in the top module
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

// ************************************************************
// Clock and frame
// ************************************************************
`define ASR_CLK_NS        100
`define ASR_FRAME_BITS    32
`define ASR_CNT_W         6
`define ASR_SCK_DIV       8
`define ASR_SCK_HALF      3'h3
`define ASR_INIT_PICK     2'h2
`define ASR_INIT_DONE     2'h3

// ************************************************************
// Timing figures
// ************************************************************
`define ASR_T_CONV60_NS   133000000
`define ASR_T_CONV50_NS   160000000
`define ASR_T_DOUT_NS     1670000
`define ASR_DOUT_OSC      256
`define ASR_EXT_CONV_OSC  20510
`define ASR_EXT_MIN_HZ    2560
`define ASR_NS_PER_S      1000000000

// ************************************************************
// States
// ************************************************************
`define ASR_ST_CONVERT    2'h0
`define ASR_ST_SLEEP      2'h1
`define ASR_ST_DOUT       2'h2

`endif

// >>> asr_fifo2.v
// Purpose: Small result buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two, AW its log2
// Notes:   Full refuses writes; empty refuses reads
module asr_fifo2 #(
    parameter W     = 31,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    input  wire         clk,
    input  wire         rst_b,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0]   cnt_q;
    wire         wr;
    wire         rd;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rp_q];
    assign wr        = in_valid & in_ready;
    assign rd        = out_valid & out_ready;

    always @(posedge clk) begin
        if (wr) begin
            mem[wp_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd) begin
                rp_q <= rp_q + 1'b1;
            end
            case ({wr, rd})
                2'b10:   cnt_q <= cnt_q + 1'b1;
                2'b01:   cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule // asr_fifo2

// >>> asr_host_model.sv
// Purpose: Host master model on the serial readout pins
// Assumes: Clock pin has a weak pull-up when nobody drives it
// Notes:   Samples data on each rising clock edge seen at the pin
module asr_host_model (
    input  wire        clk,
    input  wire        sck_o,
    input  wire        sck_oe,
    input  wire        sdo_o,
    input  wire        sdo_oe,
    output reg         cs_b,
    output wire        sck_pin,
    output reg         frame_vld,
    output reg  [31:0] frame_q,
    output reg         tmo
);
    timeunit 1ns;
    timeprecision 1ns;
    reg  host_drv;
    reg  host_sck;
    wire sdo_pin;
    assign sck_pin = sck_oe ? sck_o : (host_drv ? host_sck : 1'b1);
    // Released data line shows the inverse of the last bit
    assign sdo_pin = sdo_oe ? sdo_o : ~frame_q[0];
    initial begin
        cs_b = 1'b1;
        host_drv = 1'b1;
        host_sck = 1'b0;
        frame_vld = 1'b0;
        frame_q = 32'h0;
        tmo = 1'b0;
    end
    task read_frame(input bit ext, input integer nbits);
        integer cyc;
        integer nb;
        integer ph;
        reg     prev;
        begin
            cyc = 0;
            nb = 0;
            ph = 0;
            frame_q = 32'h0;
            @(posedge clk);
            #10;
            host_drv = ext;
            host_sck = 1'b0;
            // Pin settles first so the mode pick is clean
            repeat (4) @(posedge clk);
            #10;
            cs_b = 1'b0;
            while (!(sdo_oe === 1'b1 && sdo_pin === 1'b0) && cyc < 8000) begin
                @(posedge clk);
                #10;
                cyc = cyc + 1;
            end
            prev = sck_pin;
            while (nb < nbits && cyc < 8000) begin
                @(posedge clk);
                #10;
                cyc = cyc + 1;
                if (sck_pin && !prev) begin
                    frame_q = {frame_q[30:0], sdo_pin};
                    nb = nb + 1;
                end
                prev = sck_pin;
                ph = ph + 1;
                if (ext && ph == 6) begin
                    host_sck = ~host_sck;
                    ph = 0;
                end
            end
            repeat (6) @(posedge clk);
            #10;
            host_sck = 1'b0;
            repeat (8) @(posedge clk);
            #10;
            if (!ext || nbits < 32)
                cs_b = 1'b1;
            tmo = (cyc >= 8000);
            frame_vld = 1'b1;
            @(posedge clk);
            #10;
            frame_vld = 1'b0;
        end
    endtask
endmodule // asr_host_model

// >>> asr_readout.v
// Purpose: Conversion sequencer and serial readout of a delta-sigma converter
// Assumes: Pins synchronous-ish, resynchronised here; result word from the core
// Notes:   Serial clock mode picked at reset release and on each chip select fall
`include "asr_defs.vh"

module asr_readout #(
    parameter CONV60_CYC  = `ASR_T_CONV60_NS / `ASR_CLK_NS,
    parameter CONV50_CYC  = `ASR_T_CONV50_NS / `ASR_CLK_NS,
    parameter OSC_TICK    = `ASR_T_DOUT_NS / `ASR_DOUT_OSC / `ASR_CLK_NS,
    parameter EXT_DET_CYC = `ASR_NS_PER_S / `ASR_EXT_MIN_HZ / `ASR_CLK_NS,
    parameter EXT_CONV    = `ASR_EXT_CONV_OSC,
    parameter RES_W       = 31,
    parameter CW          = 24
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             cs_b,
    input  wire             sck_i,
    output reg              sck_o,
    output reg              sck_oe,
    output reg              sdo_o,
    output reg              sdo_oe,
    input  wire             rejection_freq_select,
    input  wire [RES_W-1:0] result_data,
    output reg              ext_osc_q,
    output reg              ext_sck_q,
    output reg  [1:0]       state_q
);

    // ************************************************************
    // Pin resynchronisation
    // ************************************************************
    wire [2:0] pin_raw;
    wire [2:0] pin_lvl;
    wire [2:0] pin_rise;
    wire [2:0] pin_fall;

    assign pin_raw = {rejection_freq_select, sck_i, cs_b};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            asr_sync_edge #(
                .RST_VAL (1'b1)
            ) u_sync (
                .clk     (clk),
                .rst_b   (rst_b),
                .din     (pin_raw[gi]),
                .level_q (pin_lvl[gi]),
                .rise    (pin_rise[gi]),
                .fall    (pin_fall[gi])
            );
        end
    endgenerate

    wire cs_lvl   = pin_lvl[0];
    wire cs_rise  = pin_rise[0];
    wire cs_fall  = pin_fall[0];
    wire sck_lvl  = pin_lvl[1];
    wire sck_rise = pin_rise[1];
    wire sck_fall = pin_fall[1];
    wire f0_lvl   = pin_lvl[2];
    wire f0_rise  = pin_rise[2];

    // ************************************************************
    // Helpers
    // ************************************************************
    function listening;
        input [1:0] st;
        begin
            listening = (st == `ASR_ST_SLEEP) || (st == `ASR_ST_DOUT);
        end
    endfunction

    // ************************************************************
    // External oscillator detection
    // ************************************************************
    // Two rises inside one window mark an oscillator; a single change
    // of the select level only picks 50 or 60 Hz rejection.
    reg [CW-1:0] det_cnt_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            det_cnt_q <= EXT_DET_CYC[CW-1:0];
            ext_osc_q <= 1'b0;
        end else if (f0_rise) begin
            det_cnt_q <= {CW{1'b0}};
            ext_osc_q <= (det_cnt_q < EXT_DET_CYC[CW-1:0]);
        end else if (det_cnt_q >= EXT_DET_CYC[CW-1:0]) begin
            ext_osc_q <= 1'b0;
        end else begin
            det_cnt_q <= det_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Conversion clock tick
    // ************************************************************
    // The internal oscillator is modelled as a divider of clk; without an external
    // oscillator its period sets the internal serial clock and the data output limit.
    reg [CW-1:0] osc_cnt_q;
    wire         int_tick = (osc_cnt_q == OSC_TICK[CW-1:0] - 1'b1);
    wire         conv_tick = ext_osc_q ? f0_rise : int_tick;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_cnt_q <= {CW{1'b0}};
        end else if (int_tick || ext_osc_q) begin
            osc_cnt_q <= {CW{1'b0}};
        end else begin
            osc_cnt_q <= osc_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Result buffer
    // ************************************************************
    reg              push;
    reg              pop;
    wire             buf_in_ready;
    wire             buf_out_valid;
    wire [RES_W-1:0] buf_out_data;

    // Conversions stall rather than overwrite an unread word
    // Occupancy never exceeds one here, so the two entries are written in turn and no stall occurs

    asr_fifo2 #(
        .W     (RES_W),
        .DEPTH (2),
        .AW    (1)
    ) u_buf (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   (result_data),
        .out_valid (buf_out_valid),
        .out_ready (pop),
        .out_data  (buf_out_data)
    );

    // ************************************************************
    // Serial clock mode selection
    // ************************************************************
    reg  [1:0] init_q;
    reg        ext_sck_d;
    wire       init_done = (init_q == `ASR_INIT_DONE);

    // The synchroniser shows its reset value for two edges after
    // release, so the power-up pick waits for the real pin level.
    always @* begin
        ext_sck_d = ext_sck_q;
        if (init_q == `ASR_INIT_PICK || (init_done && cs_fall)) begin
            ext_sck_d = ~sck_lvl;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_q    <= 2'h0;
            ext_sck_q <= 1'b0;
        end else begin
            if (!init_done) begin
                init_q <= init_q + 2'h1;
            end
            ext_sck_q <= ext_sck_d;
        end
    end

    // ************************************************************
    // Internal serial clock generator
    // ************************************************************
    // Held low outside sleep and data output so no stray edge reaches the host
    reg  [2:0] half_q;
    wire       gen_on   = ~ext_sck_q & ~cs_lvl & listening(state_q);
    wire       gen_step = gen_on & conv_tick & (half_q == `ASR_SCK_HALF);
    wire       int_rise = gen_step & ~sck_o;
    wire       int_fall = gen_step & sck_o;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_q <= 3'h0;
            sck_o  <= 1'b0;
            sck_oe <= 1'b0;
        end else begin
            // New mode gates the driver, so no clash with a host holding the pin low
            sck_oe <= ~ext_sck_d & ~cs_lvl & init_done;
            if (!gen_on) begin
                half_q <= 3'h0;
                sck_o  <= 1'b0;
            end else if (conv_tick) begin
                // Four ticks high, four low: one clock per eight ticks
                half_q <= (half_q == `ASR_SCK_HALF) ? 3'h0 : half_q + 1'b1;
                if (gen_step) begin
                    sck_o <= ~sck_o;
                end
            end
        end
    end

    wire rise_ev = ext_sck_q ? sck_rise : int_rise;
    wire fall_ev = ext_sck_q ? sck_fall : int_fall;

    // ************************************************************
    // Sequencer
    // ************************************************************
    reg [1:0]                 state_d;
    reg [CW-1:0]              conv_cnt_q;
    reg [CW-1:0]              conv_cnt_d;
    reg [`ASR_FRAME_BITS-1:0] shift_q;
    reg [`ASR_FRAME_BITS-1:0] shift_d;
    reg [`ASR_CNT_W-1:0]      bit_q;
    reg [`ASR_CNT_W-1:0]      bit_d;
    reg                       conv_done;
    reg [CW-1:0]              conv_len;

    // Length follows the select input live; a change mid-conversion
    // spoils only that result.
    always @* begin
        if (ext_osc_q) begin
            conv_len = EXT_CONV[CW-1:0];
        end else if (f0_lvl) begin
            conv_len = CONV50_CYC[CW-1:0];
        end else begin
            conv_len = CONV60_CYC[CW-1:0];
        end
    end

    // Pin events arrive three clocks after the pin moves; a host half
    // period under four clocks may be missed.
    always @* begin
        state_d    = state_q;
        conv_cnt_d = conv_cnt_q;
        shift_d    = shift_q;
        bit_d      = bit_q;
        push       = 1'b0;
        pop        = 1'b0;
        conv_done  = 1'b0;
        case (state_q)
            `ASR_ST_CONVERT: begin
                if (ext_osc_q ? f0_rise : 1'b1) begin
                    conv_cnt_d = conv_cnt_q + 1'b1;
                end
                if (conv_cnt_q >= conv_len - 1'b1) begin
                    conv_done = 1'b1;
                end
                // A full buffer holds the conversion open
                if (conv_done && buf_in_ready) begin
                    push    = 1'b1;
                    state_d = `ASR_ST_SLEEP;
                end
            end
            `ASR_ST_SLEEP: begin
                if (!cs_lvl && rise_ev && buf_out_valid) begin
                    pop     = 1'b1;
                    shift_d = {1'b0, buf_out_data};
                    bit_d   = {`ASR_CNT_W{1'b0}};
                    state_d = `ASR_ST_DOUT;
                end
            end
            `ASR_ST_DOUT: begin
                // Abort wins over a fall in the same cycle
                if (cs_rise) begin
                    conv_cnt_d = {CW{1'b0}};
                    state_d    = `ASR_ST_CONVERT;
                end else if (fall_ev) begin
                    shift_d = {shift_q[`ASR_FRAME_BITS-2:0], 1'b1};
                    bit_d   = bit_q + 1'b1;
                    if (bit_q == `ASR_FRAME_BITS - 1) begin
                        conv_cnt_d = {CW{1'b0}};
                        state_d    = `ASR_ST_CONVERT;
                    end
                end
            end
            default: begin
                conv_cnt_d = {CW{1'b0}};
                state_d    = `ASR_ST_CONVERT;
            end
        endcase
        if (state_d == `ASR_ST_CONVERT && state_q != `ASR_ST_CONVERT) begin
            conv_cnt_d = {CW{1'b0}};
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= `ASR_ST_CONVERT;
            conv_cnt_q <= {CW{1'b0}};
            shift_q    <= {`ASR_FRAME_BITS{1'b1}};
            bit_q      <= {`ASR_CNT_W{1'b0}};
        end else begin
            state_q    <= state_d;
            conv_cnt_q <= conv_cnt_d;
            shift_q    <= shift_d;
            bit_q      <= bit_d;
        end
    end

    // ************************************************************
    // Data pin
    // ************************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdo_o  <= 1'b1;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= ~cs_lvl;
            // Follows the next state so bit and clock edge leave together
            case (state_d)
                `ASR_ST_CONVERT: sdo_o <= 1'b1;
                `ASR_ST_SLEEP:   sdo_o <= 1'b0;
                `ASR_ST_DOUT:    sdo_o <= shift_d[`ASR_FRAME_BITS-1];
                default:         sdo_o <= 1'b1;
            endcase
        end
    end

endmodule // asr_readout

// >>> asr_readout_assertions.sv
// Purpose: Port checks of the serial readout block
// Assumes: Bound to asr_readout
// Notes:   Convert length is measured by the bench
`include "asr_defs.vh"
module asr_chk #(
    parameter OSC_TICK = 65
) (
    input wire       clk,
    input wire       rst_b,
    input wire       cs_b,
    input wire       sck_i,
    input wire       sck_o,
    input wire       sck_oe,
    input wire       sdo_o,
    input wire       sdo_oe,
    input wire       ext_sck_q,
    input wire [1:0] state_q
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [15:0] hi_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            hi_q <= 16'h0000;
        else
            hi_q <= sck_o ? hi_q + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ********
    // Sequences and properties
    // ********
    sequence s_cs_high; cs_b [*4]; endsequence
    sequence s_ext_pick; $fell(cs_b) && !sck_i ##1 (!cs_b && !sck_i) [*6]; endsequence
    sequence s_int_pick; $fell(cs_b) && sck_i && $past(sck_i) ##1 !cs_b [*6]; endsequence
    property p_sdo_hiz; s_cs_high |-> !sdo_oe; endproperty
    property p_ext_pick; s_ext_pick |-> ext_sck_q && !sck_oe; endproperty
    property p_int_pick; s_int_pick |-> !ext_sck_q; endproperty
    property p_sck_div;
        $fell(sck_o) && sck_oe && $past(sck_oe) |-> hi_q == 4 * OSC_TICK;
    endproperty
    property p_dout_drv; $rose(state_q == `ASR_ST_DOUT) |-> sdo_oe [*8]; endproperty
    property p_eoc_busy;
        state_q == `ASR_ST_CONVERT && $past(state_q) == `ASR_ST_CONVERT && sdo_oe
            && $past(sdo_oe) |-> sdo_o;
    endproperty
    property p_eoc_done;
        state_q == `ASR_ST_SLEEP && $past(state_q) == `ASR_ST_SLEEP && sdo_oe
            && $past(sdo_oe) |-> !sdo_o;
    endproperty
    property p_sleep_hold; s_cs_high ##0 state_q == `ASR_ST_SLEEP |=> state_q == `ASR_ST_SLEEP;
    endproperty
    property p_abort;
        state_q == `ASR_ST_DOUT && $rose(cs_b) |-> ##[1:6] state_q == `ASR_ST_CONVERT;
    endproperty
    property p_end_high;
        $past(state_q) == `ASR_ST_DOUT && state_q == `ASR_ST_CONVERT && !cs_b
            && !$past(cs_b, 6) |-> sdo_o && sdo_oe;
    endproperty
    a_sdo_hiz: assert property (p_sdo_hiz) else $error("data driven, select high");
    a_ext_pick: assert property (p_ext_pick) else $error("external mode missed");
    a_int_pick: assert property (p_int_pick) else $error("internal mode missed");
    a_sck_div: assert property (p_sck_div) else $error("clock high phase wrong");
    a_dout_drv: assert property (p_dout_drv) else $error("data not driven");
    a_eoc_busy: assert property (p_eoc_busy) else $error("flag low in convert");
    a_eoc_done: assert property (p_eoc_done) else $error("flag high in sleep");
    a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep");
    a_abort: assert property (p_abort) else $error("abort not taken");
    a_end_high: assert property (p_end_high) else $error("frame end not high");
endmodule // asr_chk

// >>> asr_sync_edge.v
// Purpose: Two-flop synchroniser with edge flags
// Assumes: Input may be asynchronous to clk
// Notes:   First flop feeds only the second flop
module asr_sync_edge #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk,
    input  wire rst_b,
    input  wire din,
    output reg  level_q,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg prev_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= RST_VAL;
            level_q <= RST_VAL;
            prev_q  <= RST_VAL;
        end else begin
            meta_q  <= din;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end

    assign rise = level_q & ~prev_q;
    assign fall = ~level_q & prev_q;
endmodule // asr_sync_edge

// >>> asr_tb.sv
// Purpose: Self-checking bench of the serial readout block
// Assumes: 100 ns clock; shortened conversion counts
// Notes:   Result word is fixed since buffered words are not tracked
`include "asr_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam C60 = 300;
    localparam C50 = 400;
    localparam EXC = 30;
    reg         clk;
    reg         rst_b;
    reg         f0_sel;
    reg         f0_run;
    reg  [1:0]  tg;
    reg  [30:0] res;
    wire        cs_b, sck_pin, sck_o, sck_oe, sdo_o, sdo_oe, ext_osc_q, ext_sck_q, fv, tmo;
    wire [1:0]  state_q;
    wire [31:0] frame;
    integer     err_count;
    integer     comparisons;
    integer     n;
    reg  [31:0] exp_q[$];
    asr_readout #(.CONV60_CYC(C60), .CONV50_CYC(C50), .OSC_TICK(2), .EXT_DET_CYC(40),
        .EXT_CONV(EXC)) dut_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck_i(sck_pin),
        .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .rejection_freq_select(f0_sel), .result_data(res), .ext_osc_q(ext_osc_q),
        .ext_sck_q(ext_sck_q), .state_q(state_q));
    asr_host_model host_u (.clk(clk), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .cs_b(cs_b), .sck_pin(sck_pin), .frame_vld(fv), .frame_q(frame),
        .tmo(tmo));
    task check(input [31:0] got, input [31:0] want);
        begin
            comparisons = comparisons + 1;
            if (got !== want) begin
                err_count = err_count + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons=%0d err_count=%0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task conv_len(input integer lo, input integer hi);
        begin
            n = 0;
            while (state_q === `ASR_ST_CONVERT && n < 20000) begin
                @(posedge clk);
                n = n + 1;
            end
            check((n >= lo && n <= hi) ? hi : n, hi);
            #10;
        end
    endtask
    task frame_rd(input bit ext, input integer nb);
        begin
            exp_q.push_back({1'b0, res} >> (32 - nb));
            host_u.read_frame(ext, nb);
            if (tmo === 1'b1) begin
                err_count = err_count + 1;
                report_and_stop;
            end
        end
    endtask
    always @(posedge clk) begin
        if (fv === 1'b1)
            check(frame, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxxxxxx);
    end
    always @(posedge clk) begin
        tg <= tg + 2'h1;
        if (f0_run && tg == 2'h3)
            f0_sel <= #10 ~f0_sel;
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        f0_sel = 1'b0;
        f0_run = 1'b0;
        tg = 2'h0;
        err_count = 0;
        comparisons = 0;
        n = $urandom(32'h0878c279);
        res = $urandom;
        repeat (4) @(posedge clk);
        #10;
        rst_b = 1'b1;
        check({sdo_oe, sck_oe, state_q}, 32'h0);
        repeat (4) @(posedge clk);
        #10;
        check(ext_sck_q, 32'h1);
        frame_rd(1'b1, 32);
        check(ext_sck_q, 32'h1);
        conv_len(C60 - 20, C60 + 2);
        f0_sel = 1'b1;
        frame_rd(1'b1, 32);
        conv_len(C50 - 20, C50 + 2);
        frame_rd(1'b1, 10);
        frame_rd(1'b0, 32);
        check(ext_sck_q, 32'h0);
        // Idle long enough for one result to wait in the buffer, then drain it
        repeat (1500) @(posedge clk);
        frame_rd(1'b1, 32);
        frame_rd(1'b1, 32);
        f0_run = 1'b1;
        n = 0;
        while (ext_osc_q !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n = n + 1;
        end
        check(ext_osc_q, 32'h1);
        frame_rd(1'b1, 32);
        conv_len(8 * EXC - 30, 8 * EXC + 8);
        f0_run = 1'b0;
        report_and_stop;
    end
endmodule // testbench
bind asr_readout asr_chk #(.OSC_TICK(OSC_TICK)) chk_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .ext_sck_q(ext_sck_q), .state_q(state_q));
